// ---- core/rpc_pkg.sv ----
// Shared constants and types of the supply, reset and oscillator trim control block
package rpc_pkg;

  // ----------------------------------------------------------------
  // Clocks and time base
  // ----------------------------------------------------------------
  localparam int REF_CLK_HZ   = 40_000_000;
  localparam int DIV_W        = 15;                      // 32768 oscillator edges make one second
  localparam int TREC_MS      = 250;                     // Power recovery delay, plain default
  localparam int TREC_CYCLES  = TREC_MS * (REF_CLK_HZ / 1000);
  localparam int REC_CNT_W    = 24;

  // ----------------------------------------------------------------
  // Square wave taps on the oscillator divider
  // ----------------------------------------------------------------
  localparam int TAP_1HZ      = 14;
  localparam int TAP_1K       = 4;
  localparam int TAP_4K       = 2;
  localparam int TAP_8K       = 1;

  // ----------------------------------------------------------------
  // Temperature conversion intervals in seconds
  // ----------------------------------------------------------------
  localparam int SEC_W        = 10;
  localparam logic [SEC_W-1:0] CONV_64S  = 10'h040;
  localparam logic [SEC_W-1:0] CONV_128S = 10'h080;
  localparam logic [SEC_W-1:0] CONV_256S = 10'h100;
  localparam logic [SEC_W-1:0] CONV_512S = 10'h200;

  // ----------------------------------------------------------------
  // Widths and serial port layout
  // ----------------------------------------------------------------
  localparam int TEMP_W       = 10;
  localparam int CAP_W        = 8;
  localparam int AGE_W        = 8;
  localparam int ADDR_W       = 7;
  localparam int WR_FLAG_BIT  = 7;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam int SYNC_W       = 7;
  localparam logic [SYNC_W-1:0] SYNC_RST = 7'h03;       // Chip select and serial clock idle high

  typedef enum logic [1:0] {CMP_IDLE, CMP_WAIT, CMP_LOOK, CMP_LOAD} rpc_cmp_state_t;
  typedef enum logic [1:0] {SPI_IDLE, SPI_ADDR, SPI_WRITE, SPI_READ} rpc_spi_state_t;

endpackage

// ---- core/rpc_power_tcxo_ctrl.sv ----
// Supply gating, power-fail reset, oscillator trim sequencing and serial port front end
`timescale 1ns/1ps
module rpc_power_tcxo_ctrl #(
  parameter int REC_CYCLES = rpc_pkg::TREC_CYCLES
) (
  input  wire logic                       i_ref_clk,
  input  wire logic                       i_rst,
  input  wire logic                       i_osc_clk,
  input  wire logic                       i_vcc_above_pf,
  input  wire logic                       i_vcc_above_bat,
  input  wire logic                       i_pf_below_bat,
  input  wire logic                       i_cs_n,
  input  wire logic                       i_sclk,
  input  wire logic                       i_din,
  input  wire logic [7:0]                 i_rd_data,
  input  wire logic                       i_osc_stop_on_battery,
  input  wire logic                       i_clk_out_enable,
  input  wire logic                       i_clk_out_on_battery,
  input  wire logic                       i_irq_or_wave_select,
  input  wire logic                       i_wave_rate_select_hi,
  input  wire logic                       i_wave_rate_select_lo,
  input  wire logic                       i_conv_rate_select_hi,
  input  wire logic                       i_conv_rate_select_lo,
  input  wire logic                       i_alarm_irq,
  input  wire logic [rpc_pkg::AGE_W-1:0]  i_aging_trim_offset,
  input  wire logic [rpc_pkg::TEMP_W-1:0] i_temp,
  input  wire logic                       i_temp_valid,
  input  wire logic [rpc_pkg::CAP_W-1:0]  i_lut_code,
  output logic                            o_dout,
  output logic                            o_dout_oe,
  output logic [rpc_pkg::ADDR_W-1:0]      o_addr,
  output logic                            o_rd_strobe,
  output logic [rpc_pkg::ADDR_W-1:0]      o_wr_addr,
  output logic [7:0]                      o_wr_data,
  output logic                            o_wr_strobe,
  output logic                            o_sclk_pol,
  output logic                            o_access_ok,
  output logic                            o_on_battery,
  output logic                            o_rst_out,
  output logic                            o_rst_oe,
  output logic                            o_osc_run,
  output logic                            o_clk_out,
  output logic                            o_irq_wave_out,
  output logic                            o_irq_wave_oe,
  output logic                            o_temp_start,
  output logic [rpc_pkg::TEMP_W-1:0]      o_lut_addr,
  output logic [rpc_pkg::CAP_W-1:0]       o_cap_sel,
  output logic                            o_cap_load
);
  localparam logic [rpc_pkg::REC_CNT_W-1:0] REC_LAST = rpc_pkg::REC_CNT_W'(REC_CYCLES - 1);

  logic [rpc_pkg::SYNC_W-1:0] sync_q;
  logic cs_n_s, sclk_s, din_s, osc_s, pf_s, bat_s, pf_lt_bat_s;

  // ----------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------
  rpc_sync #(
    .WIDTH   (rpc_pkg::SYNC_W),
    .RST_VAL (rpc_pkg::SYNC_RST)
  ) u_sync (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_async   ({i_pf_below_bat, i_vcc_above_bat, i_vcc_above_pf, i_osc_clk, i_din, i_sclk, i_cs_n}),
    .o_sync    (sync_q)
  );
  assign {pf_lt_bat_s, bat_s, pf_s, osc_s, din_s, sclk_s, cs_n_s} = sync_q;

  // ----------------------------------------------------------------
  // Power control and reset
  // ----------------------------------------------------------------
  logic                          hold_ff, nxt_hold;
  logic [rpc_pkg::REC_CNT_W-1:0] rec_ff, nxt_rec;
  logic                          blocked_ff, nxt_blocked;
  logic                          batt_ff, nxt_batt;
  logic                          armed_ff, nxt_armed;
  logic                          pf_d_ff;
  logic                          run_ff, nxt_run;

  always_comb begin
    nxt_hold    = hold_ff;
    nxt_rec     = '0;
    nxt_armed   = armed_ff | pf_s;
    nxt_batt    = pf_lt_bat_s ? !pf_s : !bat_s;
    nxt_blocked = blocked_ff;
    if (!pf_s) begin
      nxt_hold = 1'b1;
    end else if (hold_ff) begin
      // First power-up has no running oscillator to time the delay
      if (!armed_ff || i_osc_stop_on_battery) begin
        nxt_hold = 1'b0;
      end else if (rec_ff == REC_LAST) begin
        nxt_hold = 1'b0;
      end else begin
        nxt_rec = rec_ff + 1'b1;
      end
    end
    if (!pf_s && !bat_s) begin
      nxt_blocked = 1'b1;
    end else if (pf_s && bat_s && !hold_ff) begin
      nxt_blocked = 1'b0;
    end
    nxt_run = nxt_armed && !(nxt_batt && i_osc_stop_on_battery);
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      hold_ff    <= 1'b1;
      rec_ff     <= '0;
      blocked_ff <= 1'b1;
      batt_ff    <= 1'b0;
      armed_ff   <= 1'b0;
      pf_d_ff    <= 1'b0;
      run_ff     <= 1'b0;
    end else begin
      hold_ff    <= nxt_hold;
      rec_ff     <= nxt_rec;
      blocked_ff <= nxt_blocked;
      batt_ff    <= nxt_batt;
      armed_ff   <= nxt_armed;
      pf_d_ff    <= pf_s;
      run_ff     <= nxt_run;
    end
  end

  // ----------------------------------------------------------------
  // Oscillator divider, clock output and shared pin
  // ----------------------------------------------------------------
  logic                     osc_d_ff;
  logic [rpc_pkg::DIV_W-1:0] div_ff, nxt_div;
  logic                     sec_tick;
  logic                     clk_ff, nxt_clk;
  logic                     irq_oe_ff, nxt_irq_oe;
  logic                     wave;

  assign sec_tick = run_ff && osc_s && !osc_d_ff && (div_ff == '1);

  always_comb begin
    nxt_div = div_ff;
    if (run_ff && osc_s && !osc_d_ff) begin
      nxt_div = div_ff + 1'b1;
    end
    case ({i_wave_rate_select_hi, i_wave_rate_select_lo})
      2'h1:    wave = div_ff[rpc_pkg::TAP_1K];
      2'h2:    wave = div_ff[rpc_pkg::TAP_4K];
      2'h3:    wave = div_ff[rpc_pkg::TAP_8K];
      default: wave = div_ff[rpc_pkg::TAP_1HZ];
    endcase
    nxt_clk = run_ff && osc_s && i_clk_out_enable && i_clk_out_on_battery;
    if (i_irq_or_wave_select) begin
      nxt_irq_oe = i_alarm_irq;
    end else begin
      nxt_irq_oe = run_ff && !wave;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      osc_d_ff  <= 1'b0;
      div_ff    <= '0;
      clk_ff    <= 1'b0;
      irq_oe_ff <= 1'b0;
    end else begin
      osc_d_ff  <= osc_s;
      div_ff    <= nxt_div;
      clk_ff    <= nxt_clk;
      irq_oe_ff <= nxt_irq_oe;
    end
  end

  // ----------------------------------------------------------------
  // Temperature compensation
  // ----------------------------------------------------------------
  rpc_tcxo_comp u_comp (
    .i_ref_clk           (i_ref_clk),
    .i_rst               (i_rst),
    .i_start             (pf_s && !pf_d_ff),
    .i_sec_tick          (sec_tick),
    .i_conv_rate         ({i_conv_rate_select_hi, i_conv_rate_select_lo}),
    .i_aging_trim_offset (i_aging_trim_offset),
    .i_temp              (i_temp),
    .i_temp_valid        (i_temp_valid),
    .i_lut_code          (i_lut_code),
    .o_temp_start        (o_temp_start),
    .o_lut_addr          (o_lut_addr),
    .o_cap_sel           (o_cap_sel),
    .o_cap_load          (o_cap_load)
  );

  // ----------------------------------------------------------------
  // Serial port
  // ----------------------------------------------------------------
  rpc_pkg::rpc_spi_state_t   spi_ff, nxt_spi;
  logic                      cs_d_ff, sclk_d_ff;
  logic                      pol_ff, nxt_pol;
  logic [2:0]                bit_ff, nxt_bit;
  logic [7:0]                rx_ff, nxt_rx;
  logic [7:0]                tx_ff, nxt_tx;
  logic [rpc_pkg::ADDR_W-1:0] addr_ff, nxt_addr;
  logic [rpc_pkg::ADDR_W-1:0] wa_ff, nxt_wa;
  logic [7:0]                wd_ff, nxt_wd;
  logic                      ws_ff, nxt_ws;
  logic                      rs_ff, nxt_rs;
  logic                      dout_ff, nxt_dout;
  logic                      oe_ff, nxt_oe;
  logic                      samp, launch;
  logic [7:0]                byte_in;

  // Sampling edge returns the clock to its idle level (modes 1 and 3)
  assign samp    = (spi_ff != rpc_pkg::SPI_IDLE) && (sclk_d_ff != pol_ff) && (sclk_s == pol_ff);
  assign launch  = (spi_ff != rpc_pkg::SPI_IDLE) && (sclk_d_ff == pol_ff) && (sclk_s != pol_ff);
  assign byte_in = {rx_ff[6:0], din_s};

  always_comb begin
    nxt_spi  = spi_ff;
    nxt_pol  = pol_ff;
    nxt_bit  = bit_ff;
    nxt_rx   = rx_ff;
    nxt_tx   = tx_ff;
    nxt_addr = addr_ff;
    nxt_wa   = wa_ff;
    nxt_wd   = wd_ff;
    nxt_ws   = 1'b0;
    nxt_rs   = 1'b0;
    nxt_dout = dout_ff;
    if (cs_n_s) begin
      nxt_spi = rpc_pkg::SPI_IDLE;
    end else if (spi_ff == rpc_pkg::SPI_IDLE) begin
      if (cs_d_ff) begin
        nxt_pol = sclk_s;
        nxt_bit = '0;
        nxt_spi = rpc_pkg::SPI_ADDR;
      end
    end else begin
      if (samp) begin
        nxt_rx  = byte_in;
        nxt_bit = bit_ff + 3'h1;
        if (bit_ff == rpc_pkg::LAST_BIT) begin
          case (spi_ff)
            rpc_pkg::SPI_ADDR: begin
              nxt_addr = byte_in[rpc_pkg::ADDR_W-1:0];
              nxt_spi  = byte_in[rpc_pkg::WR_FLAG_BIT] ? rpc_pkg::SPI_WRITE : rpc_pkg::SPI_READ;
            end
            rpc_pkg::SPI_WRITE: begin
              nxt_wa   = addr_ff;
              nxt_wd   = byte_in;
              nxt_ws   = !blocked_ff;
              nxt_addr = addr_ff + 1'b1;
            end
            rpc_pkg::SPI_READ: nxt_addr = addr_ff + 1'b1;
            default:           nxt_spi = rpc_pkg::SPI_IDLE;
          endcase
        end
      end
      if (launch && spi_ff == rpc_pkg::SPI_READ) begin
        if (bit_ff == 3'h0) begin
          nxt_tx   = {i_rd_data[6:0], 1'b0};
          nxt_dout = i_rd_data[7];
          nxt_rs   = !blocked_ff;
        end else begin
          nxt_tx   = {tx_ff[6:0], 1'b0};
          nxt_dout = tx_ff[7];
        end
      end
    end
    nxt_oe = (nxt_spi == rpc_pkg::SPI_READ) && !blocked_ff;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      spi_ff    <= rpc_pkg::SPI_IDLE;
      cs_d_ff   <= 1'b1;
      sclk_d_ff <= 1'b1;
      pol_ff    <= 1'b0;
      bit_ff    <= '0;
      rx_ff     <= '0;
      tx_ff     <= '0;
      addr_ff   <= '0;
      wa_ff     <= '0;
      wd_ff     <= '0;
      ws_ff     <= 1'b0;
      rs_ff     <= 1'b0;
      dout_ff   <= 1'b0;
      oe_ff     <= 1'b0;
    end else begin
      spi_ff    <= nxt_spi;
      cs_d_ff   <= cs_n_s;
      sclk_d_ff <= sclk_s;
      pol_ff    <= nxt_pol;
      bit_ff    <= nxt_bit;
      rx_ff     <= nxt_rx;
      tx_ff     <= nxt_tx;
      addr_ff   <= nxt_addr;
      wa_ff     <= nxt_wa;
      wd_ff     <= nxt_wd;
      ws_ff     <= nxt_ws;
      rs_ff     <= nxt_rs;
      dout_ff   <= nxt_dout;
      oe_ff     <= nxt_oe;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_dout         = dout_ff;
  assign o_dout_oe      = oe_ff;
  assign o_addr         = addr_ff;
  assign o_rd_strobe    = rs_ff;
  assign o_wr_addr      = wa_ff;
  assign o_wr_data      = wd_ff;
  assign o_wr_strobe    = ws_ff;
  assign o_sclk_pol     = pol_ff;
  assign o_access_ok    = !blocked_ff;
  assign o_on_battery   = batt_ff;
  assign o_rst_out      = 1'b0;                                                // Open drain: only ever pulls low
  assign o_rst_oe       = hold_ff;
  assign o_osc_run      = run_ff;
  assign o_clk_out      = clk_ff;
  assign o_irq_wave_out = 1'b0;
  assign o_irq_wave_oe  = irq_oe_ff;
endmodule

// ---- core/rpc_sync.sv ----
// Two flip-flop synchroniser for levels coming from outside the reference clock domain
`timescale 1ns/1ps
module rpc_sync #(
  parameter int              WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             i_ref_clk,
  input  wire logic             i_rst,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      meta_ff <= RST_VAL;
      sync_ff <= RST_VAL;
    end else begin
      meta_ff <= i_async;
      sync_ff <= meta_ff;
    end
  end

  assign o_sync = sync_ff;
endmodule

// ---- core/rpc_tcxo_comp.sv ----
// Temperature compensation sequencer: periodic read, table lookup, aging add, load
`timescale 1ns/1ps
module rpc_tcxo_comp #(
  parameter int TEMP_W = rpc_pkg::TEMP_W,
  parameter int CAP_W  = rpc_pkg::CAP_W,
  parameter int AGE_W  = rpc_pkg::AGE_W
) (
  input  wire logic              i_ref_clk,
  input  wire logic              i_rst,
  input  wire logic              i_start,
  input  wire logic              i_sec_tick,
  input  wire logic [1:0]        i_conv_rate,
  input  wire logic [AGE_W-1:0]  i_aging_trim_offset,
  input  wire logic [TEMP_W-1:0] i_temp,
  input  wire logic              i_temp_valid,
  input  wire logic [CAP_W-1:0]  i_lut_code,
  output logic                   o_temp_start,
  output logic [TEMP_W-1:0]      o_lut_addr,
  output logic [CAP_W-1:0]       o_cap_sel,
  output logic                   o_cap_load
);
  localparam int SUM_W = CAP_W + 2;

  rpc_pkg::rpc_cmp_state_t state_ff, nxt_state;
  logic [rpc_pkg::SEC_W-1:0] sec_ff, nxt_sec;
  logic [rpc_pkg::SEC_W-1:0] interval;
  logic                      pend_ff, nxt_pend;
  logic                      have_ff, nxt_have;
  logic [TEMP_W-1:0]         prev_ff, nxt_prev;
  logic [CAP_W-1:0]          cap_ff, nxt_cap;
  logic                      start_ff, nxt_start;
  logic                      load_ff, nxt_load;
  logic signed [SUM_W-1:0]   sum;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    case (i_conv_rate)
      2'h1:    interval = rpc_pkg::CONV_128S;
      2'h2:    interval = rpc_pkg::CONV_256S;
      2'h3:    interval = rpc_pkg::CONV_512S;
      default: interval = rpc_pkg::CONV_64S;
    endcase
    sum = $signed({2'h0, i_lut_code}) + SUM_W'($signed(i_aging_trim_offset));
    nxt_state = state_ff;
    nxt_sec   = sec_ff;
    nxt_pend  = pend_ff | i_start;
    nxt_have  = have_ff;
    nxt_prev  = prev_ff;
    nxt_cap   = cap_ff;
    nxt_start = 1'b0;
    nxt_load  = 1'b0;
    if (i_sec_tick) begin
      if (sec_ff >= interval - 10'h001) begin
        nxt_sec  = '0;
        nxt_pend = 1'b1;
      end else begin
        nxt_sec = sec_ff + 10'h001;
      end
    end
    case (state_ff)
      rpc_pkg::CMP_IDLE: begin
        if (pend_ff) begin
          // Set wins: an interval that falls due in this cycle stays pending
          nxt_pend  = i_start | (i_sec_tick && sec_ff >= interval - 10'h001);
          nxt_start = 1'b1;
          nxt_state = rpc_pkg::CMP_WAIT;
        end
      end
      rpc_pkg::CMP_WAIT: begin
        if (i_temp_valid) begin
          // Aging changes wait for a temperature change by design
          if (!have_ff || i_temp != prev_ff) begin
            nxt_have  = 1'b1;
            nxt_prev  = i_temp;
            nxt_state = rpc_pkg::CMP_LOOK;
          end else begin
            nxt_state = rpc_pkg::CMP_IDLE;
          end
        end
      end
      rpc_pkg::CMP_LOOK: nxt_state = rpc_pkg::CMP_LOAD;                        // Table answers one cycle later
      rpc_pkg::CMP_LOAD: begin
        if (sum < 0) begin
          nxt_cap = '0;
        end else if (sum > $signed({2'h0, {CAP_W{1'b1}}})) begin
          nxt_cap = '1;
        end else begin
          nxt_cap = sum[CAP_W-1:0];
        end
        nxt_load  = 1'b1;
        nxt_state = rpc_pkg::CMP_IDLE;
      end
      default: nxt_state = rpc_pkg::CMP_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      state_ff <= rpc_pkg::CMP_IDLE;
      sec_ff   <= '0;
      pend_ff  <= 1'b0;
      have_ff  <= 1'b0;
      prev_ff  <= '0;
      cap_ff   <= '0;
      start_ff <= 1'b0;
      load_ff  <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      sec_ff   <= nxt_sec;
      pend_ff  <= nxt_pend;
      have_ff  <= nxt_have;
      prev_ff  <= nxt_prev;
      cap_ff   <= nxt_cap;
      start_ff <= nxt_start;
      load_ff  <= nxt_load;
    end
  end

  assign o_temp_start = start_ff;
  assign o_lut_addr   = prev_ff;
  assign o_cap_sel    = cap_ff;
  assign o_cap_load   = load_ff;
endmodule

// ---- tb/rpc_power_tcxo_ctrl_asserts.sv ----
// Concurrent checks on supply gating, reset, serial output and trim loading
`timescale 1ns/1ps
module rpc_power_tcxo_ctrl_asserts (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_vcc_above_pf,
  input wire logic i_vcc_above_bat,
  input wire logic i_cs_n,
  input wire logic i_clk_out_on_battery,
  input wire logic i_irq_or_wave_select,
  input wire logic i_alarm_irq,
  input wire logic i_temp_valid,
  input wire logic o_clk_out,
  input wire logic o_rst_oe,
  input wire logic o_access_ok,
  input wire logic o_dout_oe,
  input wire logic o_sclk_pol,
  input wire logic o_cap_load,
  input wire logic o_irq_wave_oe
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  a_rst_on_fail: assert property (!i_vcc_above_pf [*4] |-> o_rst_oe)
    else $error("reset not active on low supply");
  a_access_blocked: assert property ((!i_vcc_above_pf && !i_vcc_above_bat) [*4] |-> !o_access_ok)
    else $error("access open on backup");
  a_access_after_rst: assert property ($rose(o_access_ok) |-> !o_rst_oe)
    else $error("access reopened during reset");
  a_clk_out_off: assert property (!i_clk_out_on_battery [*4] |-> !o_clk_out)
    else $error("clock output not held low");
  a_irq_quiet: assert property ((i_irq_or_wave_select && !i_alarm_irq) [*4] |-> !o_irq_wave_oe)
    else $error("shared pin active without alarm");
  a_cap_after_temp: assert property (o_cap_load |-> $past(i_temp_valid, 3))
    else $error("capacitance load not tied to reading");
  a_dout_idle: assert property (i_cs_n [*6] |-> !o_dout_oe)
    else $error("data out driven while deselected");
  a_pol_hold: assert property (!i_cs_n [*8] |=> $stable(o_sclk_pol))
    else $error("clock polarity moved in transfer");
endmodule
bind rpc_power_tcxo_ctrl rpc_power_tcxo_ctrl_asserts i_rpc_power_tcxo_ctrl_asserts (
  .i_ref_clk, .i_rst, .i_vcc_above_pf, .i_vcc_above_bat, .i_cs_n, .i_clk_out_on_battery,
  .i_irq_or_wave_select, .i_alarm_irq, .i_temp_valid, .o_clk_out, .o_rst_oe, .o_access_ok,
  .o_dout_oe, .o_sclk_pol, .o_cap_load, .o_irq_wave_oe
);

// ---- tb/rpc_power_tcxo_ctrl_tb_top.sv ----
// Self-checking bench for the supply, reset, serial and trim control block
`timescale 1ns/1ps
module rpc_power_tcxo_ctrl_tb_top;
  logic i_ref_clk = 1'h0, i_osc_clk = 1'h0, i_rst, i_vcc_above_pf, i_vcc_above_bat, i_pf_below_bat;
  logic i_cs_n, i_sclk, i_din, i_osc_stop_on_battery, i_clk_out_enable, i_clk_out_on_battery, pc, pw;
  logic i_irq_or_wave_select, i_wave_rate_select_hi, i_wave_rate_select_lo, i_alarm_irq, i_temp_valid;
  logic i_conv_rate_select_hi = 1'h0, i_conv_rate_select_lo = 1'h0;
  logic [7:0] i_rd_data, i_aging_trim_offset, i_lut_code, o_wr_data, o_cap_sel, r0, r1, cap_seen;
  logic [9:0] i_temp, o_lut_addr;
  logic [6:0] o_addr, o_wr_addr;
  logic o_dout, o_dout_oe, o_rd_strobe, o_wr_strobe, o_sclk_pol, o_access_ok, o_on_battery, o_rst_out;
  logic o_rst_oe, o_osc_run, o_clk_out, o_irq_wave_out, o_irq_wave_oe, o_temp_start, o_cap_load;
  logic [14:0] wq[$];
  int n_fail = 0, n_compared = 0, ncap = 0, nstart = 0, nclk = 0, nwave = 0, cyc = 0, nrd = 0, c0 = 0;
  // Short recovery count keeps the power cycles brief
  rpc_power_tcxo_ctrl #(.REC_CYCLES(20)) i_rpc_power_tcxo_ctrl (.*);
  // Undriven data line shows the inverse so a missing drive cannot pass
  rpc_spi_host i_rpc_spi_host (.i_dout(o_dout_oe ? o_dout : ~o_dout), .o_cs_n(i_cs_n), .o_sclk(i_sclk), .o_din(i_din));
  assign i_rd_data  = {1'h1, o_addr};
  assign i_lut_code = o_lut_addr[7:0] + 8'h10;
  initial forever #12.5 i_ref_clk = ~i_ref_clk;
  // Fast oscillator so divided outputs show within a short run
  initial forever #200 i_osc_clk = ~i_osc_clk;
  always @(posedge i_ref_clk) begin
    cyc <= cyc + 1;
    i_temp_valid <= o_temp_start;
    pc <= o_clk_out;
    pw <= o_irq_wave_oe;
    if (o_clk_out !== pc) nclk <= nclk + 1;
    if (o_irq_wave_oe !== pw) nwave <= nwave + 1;
    if (o_temp_start) nstart <= nstart + 1;
    if (o_rd_strobe) nrd <= nrd + 1;
    if (o_wr_strobe) wq.push_back({o_wr_addr, o_wr_data});
    if (o_cap_load) begin
      ncap <= ncap + 1;
      cap_seen <= o_cap_sel;
    end
    if (cyc == 30000) begin
      n_fail++;
      finish_test();
    end
  end
  task automatic step(input int n);
    repeat (n) @(posedge i_ref_clk);
    #2;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("Compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    {i_vcc_above_pf, i_vcc_above_bat, i_osc_stop_on_battery, i_irq_or_wave_select, i_alarm_irq} = '0;
    {i_wave_rate_select_hi, i_wave_rate_select_lo} = '0;
    {i_rst, i_pf_below_bat, i_clk_out_enable, i_clk_out_on_battery} = 4'hF;
    i_aging_trim_offset = 8'h03;
    i_temp = 10'h020;
    step(20);
    chk({o_rst_oe, o_access_ok}, 2'h2);
    i_rst = 1'h0;
    step(10);
    chk({o_osc_run, o_access_ok}, 2'h0);
    {i_vcc_above_pf, i_vcc_above_bat} = 2'h3;
    step(12);
    chk({o_rst_oe, o_access_ok, o_osc_run}, 3'h3);
    chk({nstart[7:0], ncap[7:0]}, 16'h0101);
    chk({o_lut_addr, cap_seen}, {10'h020, 8'h33});
    for (int p = 0; p < 2; p++) begin
      i_rpc_spi_host.frame(p[0], 8'h85, 8'hA5, 8'h3C + p[7:0], r0, r1);
      chk(o_sclk_pol, p[0]);
      chk(wq.size(), 32'h2);
      chk({wq[0], wq[1]}, {7'h05, 8'hA5, 7'h06, 8'h3C + p[7:0]});
      wq.delete();
      i_rpc_spi_host.frame(p[0], 8'h10, 8'h00, 8'h00, r0, r1);
      chk({r0, r1, o_dout_oe}, {16'h9091, 1'h0});
    end
    i_vcc_above_pf = 1'h0;
    step(6);
    chk({o_rst_oe, o_access_ok, o_on_battery}, 3'h7);
    i_vcc_above_bat = 1'h0;
    step(6);
    chk({o_access_ok, o_osc_run}, 2'h1);
    i_osc_stop_on_battery = 1'h1;
    i_aging_trim_offset = 8'h07;
    step(6);
    chk(o_osc_run, 1'h0);
    i_rpc_spi_host.frame(1'h1, 8'h87, 8'h11, 8'h22, r0, r1);
    chk(wq.size(), 16'h0);
    {i_vcc_above_pf, i_vcc_above_bat} = 2'h3;
    step(8);
    chk({o_rst_oe, o_access_ok}, 2'h1);
    {i_osc_stop_on_battery, i_pf_below_bat, i_vcc_above_pf} = 3'h0;
    step(6);
    chk(o_on_battery, 1'h0);
    i_vcc_above_bat = 1'h0;
    step(6);
    chk(o_on_battery, 1'h1);
    {i_vcc_above_pf, i_vcc_above_bat} = 2'h3;
    step(10);
    chk({o_rst_oe, o_access_ok}, 2'h2);
    step(30);
    chk({o_rst_oe, o_access_ok}, 2'h1);
    c0 = nclk;
    step(200);
    chk(nclk > c0, 1'h1);
    i_clk_out_on_battery = 1'h0;
    step(4);
    c0 = nclk;
    step(200);
    chk({nclk[7:0] - c0[7:0], o_clk_out}, 9'h0);
    for (int r = 1; r < 4; r++) begin
      {i_wave_rate_select_hi, i_wave_rate_select_lo} = r[1:0];
      step(4);
      c0 = nwave;
      step(800);
      chk(nwave > c0, 1'h1);
    end
    {i_irq_or_wave_select, i_alarm_irq} = 2'h3;
    step(6);
    chk(o_irq_wave_oe, 1'h1);
    i_alarm_irq = 1'h0;
    step(6);
    c0 = nwave;
    step(100);
    chk({nwave[7:0] - c0[7:0], o_irq_wave_oe}, 9'h0);
    chk({nstart[7:0], ncap[7:0], cap_seen}, 24'h030133);
    chk(nrd, 32'h4);
    finish_test();
  end
endmodule

// ---- tb/rpc_spi_host.sv ----
// Host serial master model driving select, clock and data into the device
`timescale 1ns/1ps
module rpc_spi_host (
  input  wire logic i_dout,
  output logic      o_cs_n,
  output logic      o_sclk,
  output logic      o_din
);
  initial begin
    o_cs_n = 1'h1;
    o_sclk = 1'h1;
    o_din  = 1'h0;
  end
  task automatic xbyte(input logic pol, input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      o_sclk = ~pol;
      o_din  = tx[i];
      #100;
      o_sclk = pol;
      #100;
      rx[i] = i_dout;
    end
  endtask
  // Clock rests at the idle level before select so the device sees it there
  task automatic frame(input logic pol, input logic [7:0] a, d0, d1, output logic [7:0] r0, r1);
    logic [7:0] ra;
    o_sclk = pol;
    #200;
    o_cs_n = 1'h0;
    #200;
    xbyte(pol, a, ra);
    xbyte(pol, d0, r0);
    xbyte(pol, d1, r1);
    #200;
    o_cs_n = 1'h1;
    o_din  = ~o_din;
    #400;
  endtask
endmodule
